// File: inc/opamp_ctrl_defs.svh
// Purpose: Register offsets, field positions, reset values and codes for the amplifier control block.
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register.
// Notes: Included by the design modules and by the testbench.
`ifndef OPAMP_CTRL_DEFS_SVH
`define OPAMP_CTRL_DEFS_SVH

`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_CTRL2 8'h08
`define OFS_CTRL3 8'h0C
`define OFS_HWCFG 8'h10
`define OFS_TRIM 8'h14
`define OFS_ADCSEL 8'h18
`define OFS_STATUS 8'h1C

`define CTRL0_RESET 32'h0000_0000
`define CTRL1_RESET 32'h0000_0000
`define CTRL2_RESET 32'h0000_0000
`define CTRL3_RESET 32'h0000_0000
`define HWCFG_RESET 32'h0000_0000
`define ADCSEL_RESET 32'h0000_0000

`define CTRL0_EN_BIT 7
`define CTRL0_UG_BIT 3
`define CTRL0_SOC_LSB 0
`define CTRL1_GAIN_LSB 4
`define CTRL1_LADDER_BIT 3
`define CTRL1_NSS_LSB 0
`define CTRL2_NCH_LSB 4
`define CTRL2_PCH_LSB 0
`define CTRL3_PSS_LSB 0
`define HWCFG_OVERRIDE_ENABLE_BIT 7
`define HWCFG_OVERRIDE_POLARITY_BIT 6
`define HWCFG_HIGH_LSB 4
`define HWCFG_LOW_LSB 2
`define HWCFG_ORS_LSB 0
`define ADCSEL_MODE_BIT 7
`define ADCSEL_PIN_LSB 0

`define SOC_BASIC 2'h0
`define SOC_LOW 2'h1
`define SOC_HIGH 2'h2
`define HW_BASIC 2'h0
`define HW_UNITY 2'h1
`define HW_RAIL 2'h2

`define CH_PIN 3'h2
`define CH_LADDER 3'h1
`define TRIM_FACTORY 8'h80

`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// File: inc/opamp_ctrl_pkg.sv
// Purpose: Shared types for the amplifier control block.
// Assumes: Constants live in opamp_ctrl_defs.svh.
// Notes: Drive mode is the resolved amplifier output behaviour.
package opamp_ctrl_pkg;

   typedef enum logic [1:0] {
      drive_linear,
      drive_rail_low,
      drive_rail_high,
      drive_off
   } drive_type;

   typedef enum logic [1:0] {
      bus_idle,
      bus_resp
   } bus_state_type;

endpackage : opamp_ctrl_pkg

// File: inc/mode_if.sv
// Purpose: Carries the software mode fields to the override resolver and the resolved mode back.
// Assumes: Single clock domain.
// Notes: None.
`timescale 1ns/1ps
interface mode_if;
   import opamp_ctrl_pkg::*;
   logic override_enable;
   logic override_polarity;
   logic [1:0] override_source_sel;
   logic [1:0] mode_when_high;
   logic [1:0] mode_when_low;
   logic [1:0] soc;
   logic unity_gain_sel;
   drive_type drive;
   logic unity;
   modport ctrl (output override_enable, override_polarity, override_source_sel, mode_when_high,
      mode_when_low, soc, unity_gain_sel, input drive, unity);
   modport res (input override_enable, override_polarity, override_source_sel, mode_when_high,
      mode_when_low, soc, unity_gain_sel, output drive, unity);
endinterface : mode_if

// File: rtl/override_resolver.sv
// Purpose: Picks the amplifier mode from software fields or the sampled override signal.
// Assumes: Override sources are synchronous to aclk.
// Notes: Outputs are registered so a source change shows one cycle later.
`timescale 1ns/1ps
`include "opamp_ctrl_defs.svh"
module override_resolver
   import opamp_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] override_src,
   mode_if.res m
);
   drive_type drive_d;
   drive_type drive_q;
   logic unity_d;
   logic unity_q;
   logic level;
   logic [1:0] hw_mode;

   always_comb begin
      level = override_src[m.override_source_sel] ^ m.override_polarity;
      hw_mode = level ? m.mode_when_high : m.mode_when_low;
      drive_d = drive_linear;
      unity_d = 1'b0;
      if (m.override_enable) begin
         case (hw_mode)
            `HW_BASIC: drive_d = drive_linear;
            `HW_UNITY: begin
               drive_d = drive_linear;
               unity_d = 1'b1;
            end
            `HW_RAIL: drive_d = level ? drive_rail_high : drive_rail_low;
            default: drive_d = drive_off;
         endcase
      end else begin
         unity_d = m.unity_gain_sel;
         case (m.soc)
            `SOC_BASIC: drive_d = drive_linear;
            `SOC_LOW: drive_d = drive_rail_low;
            `SOC_HIGH: drive_d = drive_rail_high;
            default: drive_d = drive_off;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_q <= drive_linear;
         unity_q <= 1'b0;
      end else begin
         drive_q <= drive_d;
         unity_q <= unity_d;
      end
   end

   assign m.drive = drive_q;
   assign m.unity = unity_q;

   override_lag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      m.override_enable && (override_src[m.override_source_sel] ^ m.override_polarity)
      && m.mode_when_high == `HW_RAIL |=> m.drive == drive_rail_high)
      else $error("Override rail high not applied one cycle later.");
   sw_unity_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !m.override_enable |=> (m.unity == $past(m.unity_gain_sel)))
      else $error("Unity gain does not follow software select.");
endmodule : override_resolver

// File: rtl/axil_regs.sv
// Purpose: AXI4-Lite slave holding the amplifier control registers.
// Assumes: One read and one write outstanding at most.
// Notes: Unmapped addresses answer SLVERR; read data of them is zero.
`timescale 1ns/1ps
`include "opamp_ctrl_defs.svh"
module axil_regs
   import opamp_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [31:0] status,
   output logic [31:0] regs_flat [0:6]
);
   logic [31:0] regs_d [0:6];
   logic [31:0] regs_q [0:6];
   logic aw_d, aw_q, w_d, w_q, b_d, b_q, r_d, r_q;
   logic [7:0] awa_d, awa_q;
   logic [31:0] wd_d, wd_q;
   logic [3:0] ws_d, ws_q;
   logic [1:0] bresp_d, bresp_q, rresp_d, rresp_q;
   logic [31:0] rdata_d, rdata_q;

   function automatic logic [3:0] decode(input logic [7:0] a);
      decode = (a[1:0] == 2'h0 && a <= `OFS_STATUS) ? 4'(a[7:2]) : 4'hF;
   endfunction : decode

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
   endfunction : merge

   always_comb begin
      logic [3:0] idx;
      idx = 4'h0;
      regs_d = regs_q;
      aw_d = aw_q;
      w_d = w_q;
      b_d = b_q && !bready;
      r_d = r_q && !rready;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bresp_d = bresp_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (awvalid && !aw_q && !b_q) begin
         aw_d = 1'b1;
         awa_d = awaddr;
      end
      if (wvalid && !w_q && !b_q) begin
         w_d = 1'b1;
         wd_d = wdata;
         ws_d = wstrb;
      end
      if (aw_q && w_q) begin
         idx = decode(awa_q);
         aw_d = 1'b0;
         w_d = 1'b0;
         b_d = 1'b1;
         bresp_d = `AXI_OKAY;
         if (idx < 4'h7) regs_d[idx[2:0]] = merge(regs_q[idx[2:0]], wd_q, ws_q);
         else if (idx != 4'h7) bresp_d = `AXI_SLVERR;
      end
      if (arvalid && !r_q) begin
         idx = decode(araddr);
         r_d = 1'b1;
         rresp_d = (idx == 4'hF) ? `AXI_SLVERR : `AXI_OKAY;
         rdata_d = (idx == 4'h7) ? status : (idx < 4'h7) ? regs_q[idx[2:0]] : 32'h0000_0000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         regs_q[0] <= `CTRL0_RESET;
         regs_q[1] <= `CTRL1_RESET;
         regs_q[2] <= `CTRL2_RESET;
         regs_q[3] <= `CTRL3_RESET;
         regs_q[4] <= `HWCFG_RESET;
         regs_q[5] <= {24'h00_0000, `TRIM_FACTORY};
         regs_q[6] <= `ADCSEL_RESET;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         b_q <= 1'b0;
         r_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bresp_q <= `AXI_OKAY;
         rresp_q <= `AXI_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         regs_q <= regs_d;
         aw_q <= aw_d;
         w_q <= w_d;
         b_q <= b_d;
         r_q <= r_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign awready = !aw_q && !b_q;
   assign wready = !w_q && !b_q;
   assign bvalid = b_q;
   assign bresp = bresp_q;
   assign arready = !r_q;
   assign rvalid = r_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign regs_flat = regs_q;

   trim_reset_a: assert property (@(posedge aclk) $rose(aresetn) |-> regs_q[5][7:0] == `TRIM_FACTORY)
      else $error("Trim not at factory value after reset.");
   bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) bvalid && !bready |=> bvalid)
      else $error("Write response dropped before accepted.");
   write_cov: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);
   read_cov: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);
endmodule : axil_regs

// File: rtl/opamp_mode_override_control.sv
// Purpose: Digital control around the on-chip amplifier: enable, pin tri-state, mode, routing, trim.
// Assumes: Override sources and ADC controls are synchronous to aclk.
// Notes: All outputs are registered; mode changes pass the resolver and the pin flops, reaching the pins two cycles after the cause.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "opamp_ctrl_defs.svh"

// Contract
// - Enable set forces the output pin's port driver to high impedance.
// - Override clear takes the mode from the software output control field.
// - Unity gain with override clear ties output to inverting input, freeing that pin.
// - Positive channel field routes noninverting input; pin select picks the external pin.
// - Negative channel field routes inverting input; pin select picks the external pin.
// - Ladder active only while enabled; gain select then picks the tap.
// - Channel fields can connect the ladder to either input as feedback.
// - Override enable hands mode control to the selected override signal.
// - Override high applies the high setting, low applies the low setting.
// - Polarity one inverts the override signal before choosing a setting.
// - Override modes are basic, unity gain, or rail drive following the signal.
// - Trim writes adjust offset; any reset reloads the factory value.
// - In ADC mode amplifier output feeds the ADC; ADC may pick positive pin.
// - Output control codes: basic, drive low, drive high, reserved.
// - Positive channel codes: ground, ladder, pin, half supply, two DAC outputs.
// - In ADC mode the ADC pin choice overrides the positive pin-select field.
module opamp_mode_override_control
   import opamp_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [7:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   input wire logic [3:0] override_src,
   input wire logic [2:0] adc_pos_channel,
   output logic amp_enable,
   output logic amp_output_pin_port_oe_n,
   output logic [1:0] amp_drive,
   output logic unity_gain_sel,
   output logic [2:0] pos_channel_sel,
   output logic [1:0] pos_pin_sel,
   output logic [2:0] neg_channel_sel,
   output logic [2:0] neg_pin_sel,
   output logic neg_pin_free,
   output logic ladder_enable,
   output logic [2:0] gain_sel,
   output logic [7:0] offset_trim,
   output logic adc_route_amp
);
   logic [31:0] regs [0:6];
   logic [31:0] status;
   logic s_bvalid, s_arready, s_awready, s_wready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   mode_if m ();

   axil_regs u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axil_awaddr),
      .awvalid(s_axil_awvalid),
      .awready(s_awready),
      .wdata(s_axil_wdata),
      .wstrb(s_axil_wstrb),
      .wvalid(s_axil_wvalid),
      .wready(s_wready),
      .bresp(s_bresp),
      .bvalid(s_bvalid),
      .bready(s_axil_bready),
      .araddr(s_axil_araddr),
      .arvalid(s_axil_arvalid),
      .arready(s_arready),
      .rdata(s_rdata),
      .rresp(s_rresp),
      .rvalid(s_rvalid),
      .rready(s_axil_rready),
      .status(status),
      .regs_flat(regs)
   );

   // The bus handshake outputs are registered inside the slave; the ready terms are gated flops.
   assign s_axil_awready = s_awready;
   assign s_axil_wready = s_wready;
   assign s_axil_bresp = s_bresp;
   assign s_axil_bvalid = s_bvalid;
   assign s_axil_arready = s_arready;
   assign s_axil_rdata = s_rdata;
   assign s_axil_rresp = s_rresp;
   assign s_axil_rvalid = s_rvalid;

   assign m.override_enable = regs[4][`HWCFG_OVERRIDE_ENABLE_BIT];
   assign m.override_polarity = regs[4][`HWCFG_OVERRIDE_POLARITY_BIT];
   assign m.override_source_sel = regs[4][`HWCFG_ORS_LSB +: 2];
   assign m.mode_when_high = regs[4][`HWCFG_HIGH_LSB +: 2];
   assign m.mode_when_low = regs[4][`HWCFG_LOW_LSB +: 2];
   assign m.soc = regs[0][`CTRL0_SOC_LSB +: 2];
   assign m.unity_gain_sel = regs[0][`CTRL0_UG_BIT];

   override_resolver u_res (
      .aclk(aclk),
      .aresetn(aresetn),
      .override_src(override_src),
      .m(m)
   );

   logic en_d, en_q, oe_n_d, oe_n_q, ug_d, ug_q, free_d, free_q, lad_d, lad_q, adc_d, adc_q;
   logic [1:0] drv_d, drv_q, pss_d, pss_q;
   logic [2:0] pch_d, pch_q, nch_d, nch_q, nss_d, nss_q, gain_d, gain_q;
   logic [7:0] trim_d, trim_q;

   always_comb begin
      en_d = regs[0][`CTRL0_EN_BIT];
      oe_n_d = en_d;
      drv_d = en_d ? 2'(m.drive) : 2'(drive_off);
      ug_d = m.unity;
      free_d = m.unity;
      pch_d = regs[2][`CTRL2_PCH_LSB +: 3];
      nch_d = ug_d ? 3'h0 : regs[2][`CTRL2_NCH_LSB +: 3];
      adc_d = regs[6][`ADCSEL_MODE_BIT];
      pss_d = regs[3][`CTRL3_PSS_LSB +: 2];
      if (adc_d) pss_d = adc_pos_channel[1:0];
      nss_d = regs[1][`CTRL1_NSS_LSB +: 3];
      lad_d = regs[1][`CTRL1_LADDER_BIT];
      gain_d = lad_d ? regs[1][`CTRL1_GAIN_LSB +: 3] : 3'h0;
      trim_d = regs[5][7:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= 1'b0;
         oe_n_q <= 1'b0;
         drv_q <= 2'(drive_off);
         ug_q <= 1'b0;
         free_q <= 1'b0;
         pch_q <= 3'h0;
         nch_q <= 3'h0;
         pss_q <= 2'h0;
         nss_q <= 3'h0;
         lad_q <= 1'b0;
         gain_q <= 3'h0;
         trim_q <= `TRIM_FACTORY;
         adc_q <= 1'b0;
      end else begin
         en_q <= en_d;
         oe_n_q <= oe_n_d;
         drv_q <= drv_d;
         ug_q <= ug_d;
         free_q <= free_d;
         pch_q <= pch_d;
         nch_q <= nch_d;
         pss_q <= pss_d;
         nss_q <= nss_d;
         lad_q <= lad_d;
         gain_q <= gain_d;
         trim_q <= trim_d;
         adc_q <= adc_d;
      end
   end

   // Status shows the resolved mode so software can see the override take effect.
   assign status = {24'h00_0000, 3'h0, ug_q, drv_q, en_q, adc_q};

   assign amp_enable = en_q;
   assign amp_output_pin_port_oe_n = oe_n_q;
   assign amp_drive = drv_q;
   assign unity_gain_sel = ug_q;
   assign pos_channel_sel = pch_q;
   assign pos_pin_sel = pss_q;
   assign neg_channel_sel = nch_q;
   assign neg_pin_sel = nss_q;
   assign neg_pin_free = free_q;
   assign ladder_enable = lad_q;
   assign gain_sel = gain_q;
   assign offset_trim = trim_q;
   assign adc_route_amp = adc_q;

   pin_tristate_a: assert property (@(posedge aclk) disable iff (!aresetn) amp_enable |-> amp_output_pin_port_oe_n)
      else $error("Output pin port driver active while amplifier enabled.");
   sw_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      en_d && !m.override_enable && $stable(m.override_enable) && m.soc == `SOC_LOW
      && $past(m.soc) == `SOC_LOW ##1 $past(m.soc) == `SOC_LOW |-> amp_drive == 2'(drive_rail_low))
      else $error("Software drive low not applied.");
   ladder_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) !ladder_enable |-> gain_sel == 3'h0)
      else $error("Gain tap selected with ladder off.");
   adc_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
      adc_d |=> pos_pin_sel == $past(adc_pos_channel[1:0]))
      else $error("ADC pin choice not taking precedence.");
   trim_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) 1'b1 |=> offset_trim == $past(regs[5][7:0]))
      else $error("Trim output not following register.");
   unity_frees_a: assert property (@(posedge aclk) disable iff (!aresetn) unity_gain_sel |-> neg_pin_free && neg_channel_sel == 3'h0)
      else $error("Unity gain did not free the inverting pin.");
   override_cov: cover property (@(posedge aclk) disable iff (!aresetn) m.override_enable && $changed(amp_drive));
   adc_cov: cover property (@(posedge aclk) disable iff (!aresetn) adc_route_amp && amp_enable);
   unity_cov: cover property (@(posedge aclk) disable iff (!aresetn) unity_gain_sel && amp_enable);
endmodule : opamp_mode_override_control

// File: tb/src_adc_model.sv
// Purpose: Stands in for the override source signals and the converter's pin choice.
// Assumes: Both are synchronous to aclk.
// Notes: Levels change just after a clock edge, so the design never samples a level mid-change.
`timescale 1ns/1ps
module src_adc_model (
   input wire logic aclk,
   input wire logic [3:0] level_req,
   input wire logic [2:0] pin_req,
   output logic [3:0] override_src,
   output logic [2:0] adc_pos_channel
);
   always @(posedge aclk) begin
      override_src <= level_req;
      adc_pos_channel <= pin_req;
   end
endmodule : src_adc_model

// File: tb/opamp_mode_override_control_tb.sv
// Purpose: Self-checking bench for the amplifier control block.
// Assumes: Registers are reached over AXI4-Lite; sources come from src_adc_model.
// Notes: Expected pin values come from shadow copies of the registers, never from the design.
`timescale 1ns/1ps
`include "opamp_ctrl_defs.svh"
module opamp_mode_override_control_tb;
   import opamp_ctrl_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] aw = 8'h00;
   logic [7:0] ar = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'hF;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic awr, wr_rdy, bv, arr, rv;
   logic [1:0] bresp, rresp, amp_drive, pos_pin, rs;
   logic [31:0] rdata, rd;
   logic [3:0] src_req = 4'h0;
   logic [3:0] override_src;
   logic [2:0] pin_req = 3'h0;
   logic [2:0] adc_pos_channel, pos_ch, neg_ch, neg_pin, gain;
   logic amp_en, oe_n, ug, neg_free, ladder, adc_route;
   logic [7:0] trim;
   logic [31:0] sh [0:6];
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;

   src_adc_model partner (.aclk(aclk), .level_req(src_req), .pin_req(pin_req),
      .override_src(override_src), .adc_pos_channel(adc_pos_channel));

   opamp_mode_override_control uut (.aclk(aclk), .aresetn(aresetn),
      .s_axil_awaddr(aw), .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_wdata(wd),
      .s_axil_wstrb(ws), .s_axil_wvalid(wv), .s_axil_wready(wr_rdy), .s_axil_bresp(bresp),
      .s_axil_bvalid(bv), .s_axil_bready(bre), .s_axil_araddr(ar), .s_axil_arvalid(arv),
      .s_axil_arready(arr), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rv),
      .s_axil_rready(rre), .override_src(override_src), .adc_pos_channel(adc_pos_channel),
      .amp_enable(amp_en), .amp_output_pin_port_oe_n(oe_n), .amp_drive(amp_drive),
      .unity_gain_sel(ug), .pos_channel_sel(pos_ch), .pos_pin_sel(pos_pin),
      .neg_channel_sel(neg_ch), .neg_pin_sel(neg_pin), .neg_pin_free(neg_free),
      .ladder_enable(ladder), .gain_sel(gain), .offset_trim(trim), .adc_route_amp(adc_route));

   initial begin
      forever #4 aclk = ~aclk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // The ceiling is far above the roughly 700 cycles the tests need.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
         mismatches++;
      end
   endtask : ck

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      bre <= 1'b0;
      ck({31'h0, bv}, 32'h1, "write answer");
      ck({30'h0, bresp}, {30'h0, er}, "write response");
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      ar <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      rre <= 1'b0;
      d = rdata;
      r = rresp;
      ck({31'h0, rv}, 32'h1, "read answer");
   endtask : axr

   task automatic wr(input int i, input logic [31:0] d);
      sh[i] = d;
      axw(8'(i * 4), d, `AXI_OKAY);
   endtask : wr

   // Returns {unity, drive} as the pins should show them.
   function automatic logic [2:0] exp_mode(input logic [31:0] c0, input logic [31:0] hw,
      input logic [3:0] s);
      logic lvl;
      logic [1:0] md;
      logic [1:0] drv;
      logic un;
      lvl = s[hw[1:0]] ^ hw[6];
      md = lvl ? hw[5:4] : hw[3:2];
      un = hw[7] ? (md == `HW_UNITY) : c0[3];
      drv = !hw[7] ? c0[1:0] : (md == `HW_RAIL) ? {lvl, !lvl} : (md == 2'h3) ? 2'h3 : 2'h0;
      if (!c0[7]) drv = 2'h3;
      return {un, drv};
   endfunction : exp_mode

   task automatic check_all;
      logic [2:0] m;
      logic [1:0] pp;
      repeat (4) @(posedge aclk);
      m = exp_mode(sh[0], sh[4], src_req);
      pp = sh[6][7] ? pin_req[1:0] : sh[3][1:0];
      ck({2'h0, amp_en, oe_n, amp_drive, ug, pos_ch, pos_pin, neg_ch, neg_pin, neg_free, ladder,
         gain, trim, adc_route},
         {2'h0, sh[0][7], sh[0][7], m[1:0], m[2], sh[2][2:0], pp, m[2] ? 3'h0 : sh[2][6:4],
         sh[1][2:0], m[2], sh[1][3], sh[1][3] ? sh[1][6:4] : 3'h0, sh[5][7:0], sh[6][7]}, "pins");
      axr(`OFS_STATUS, rd, rs);
      ck(rd, {27'h0, m[2], m[1:0], sh[0][7], sh[6][7]}, "status");
   endtask : check_all

   task automatic clear_shadow;
      for (int i = 0; i < 7; i++) sh[i] = 32'h0;
      sh[5] = {24'h0, `TRIM_FACTORY};
   endtask : clear_shadow

   initial begin
      void'($urandom(32'hF882));
      clear_shadow();
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         axr(8'(i * 4), rd, rs);
         ck(rd, sh[i], "reset value");
      end
      check_all();
      axr(8'h20, rd, rs);
      ck({30'h0, rs}, {30'h0, `AXI_SLVERR}, "unmapped read");
      ck(rd, 32'h0, "unmapped data");
      axw(8'h02, 32'hFF, `AXI_SLVERR);
      axw(`OFS_STATUS, 32'hFFFF_FFFF, `AXI_OKAY);
      check_all();
      $display("test reset and map done");
      for (int s = 0; s < 4; s++) begin
         wr(0, 32'h80 | s);
         check_all();
      end
      wr(0, 32'h88);
      wr(2, 32'h22);
      check_all();
      $display("test software mode done");
      wr(0, 32'h80);
      wr(2, 32'h11);
      wr(1, 32'h78);
      check_all();
      wr(1, 32'h70);
      check_all();
      repeat (8) begin
         wr(1, $urandom);
         wr(2, $urandom);
         wr(3, $urandom);
         check_all();
      end
      $display("test routing done");
      // Hand-picked rail drive on the high setting, both polarities and both source levels.
      for (int p = 0; p < 4; p++) begin
         wr(4, 32'hA0 | (p[1] ? 32'h40 : 32'h0));
         src_req <= {3'h0, p[0]};
         check_all();
      end
      repeat (24) begin
         wr(4, $urandom);
         src_req <= 4'($urandom);
         check_all();
      end
      $display("test override done");
      // Recalibration as software does it: unity gain, pin reference, then a new trim.
      wr(4, 32'h0);
      wr(0, 32'h88);
      wr(2, 32'h02);
      wr(5, $urandom & 32'hFF);
      check_all();
      ws <= 4'hE;
      axw(`OFS_TRIM, 32'h0000_0055, `AXI_OKAY);
      ws <= 4'hF;
      axr(`OFS_TRIM, rd, rs);
      ck(rd, sh[5], "masked trim byte");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      clear_shadow();
      check_all();
      $display("test trim done");
      for (int k = 0; k < 4; k++) begin
         pin_req <= 3'($urandom);
         wr(3, $urandom);
         wr(6, {24'h0, k[0], 7'h0});
         check_all();
      end
      $display("test converter route done");
      give_verdict();
   end
endmodule : opamp_mode_override_control_tb
